// >>> core/rtc_defines.vh
`ifndef RTC_DEFINES_VH
`define RTC_DEFINES_VH
`define CLK_HZ          100000000
`define TICK_CYCLES     (`CLK_HZ)
`define A_TIME          4'h0
`define A_DAYS          4'h1
`define A_CAL           4'h2
`define A_OFFSET        4'h3
`define A_SERVER        4'h4
`define A_NET_LOAD      4'h5
`define SEC_MAX         6'h3B
`define HOUR_MAX        5'h17
`define YEAR_MAX        7'h63
`define OFFSET_MAX      5'h0C
`define F_SEC_LSB       0
`define F_MIN_LSB       8
`define F_HOUR_LSB      16
`define F_WDAY_LSB      0
`define F_MDAY_LSB      8
`define F_MON_LSB       16
`define F_YEAR_LSB      24
`endif

// >>> core/time_of_day_calendar_clock.v
`include "rtc_defines.vh"
module time_of_day_calendar_clock #(
  parameter TICK_CYCLES = `TICK_CYCLES
)
(
  input  wire        ref_clk,
  input  wire        srst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        ntp_valid,
  input  wire [31:0] ntp_seconds
);

  reg  [5:0]  seconds_field;
  reg  [5:0]  minutes_field;
  reg  [4:0]  hours_field;
  reg  [15:0] elapsed_day_count;
  reg  [2:0]  weekday_field;
  reg  [4:0]  month_day_field;
  reg  [3:0]  month_field;
  reg  [6:0]  year_field;
  reg  [4:0]  current_utc_offset;
  reg  [31:0] last_server_time_value;
  reg  [31:0] tick_cnt;
  reg  [31:0] ntp_sod;
  reg  [31:0] ntp_sec_full;
  reg  [31:0] ntp_min_full;
  reg  [31:0] ntp_hour_full;
  reg         ntp_pend;
  reg  [5:0]  ntp_sec;
  reg  [5:0]  ntp_min;
  reg  [4:0]  ntp_hour_utc;
  reg  [5:0]  loc_hour;
  reg  [4:0]  month_len;
  reg  [31:0] rd_data;
  wire [3:0]  reg_idx;
  wire        wb_req;
  wire        tick;
  wire        cal_on;
  wire        leap;
  wire        day_wrap;
  wire        ld_time;
  wire        ld_net;

  assign reg_idx = wb_adr_i[5:2];
  assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign tick    = (tick_cnt == TICK_CYCLES - 1);
  assign cal_on  = (weekday_field != 3'h0) && (month_field != 4'h0);
  assign leap    = (year_field[1:0] == 2'h0);
  assign ld_time = wb_req & wb_we_i & (reg_idx == `A_TIME);
  assign ld_net  = ntp_pend;
  assign day_wrap = tick && seconds_field == `SEC_MAX && minutes_field == `SEC_MAX
                    && hours_field == `HOUR_MAX;

  // Month length for calendar wrap
  always @*
  begin
    case (month_field)
      4'h2:    month_len = leap ? 5'h1D : 5'h1C;
      4'h4:    month_len = 5'h1E;
      4'h6:    month_len = 5'h1E;
      4'h9:    month_len = 5'h1E;
      4'hB:    month_len = 5'h1E;
      default: month_len = 5'h1F;
    endcase
  end

  // Network time: seconds of day split, offset applied to hours
  always @*
  begin
    ntp_sec_full  = ntp_sod % 60;
    ntp_min_full  = (ntp_sod / 60) % 60;
    ntp_hour_full = (ntp_sod / 3600) % 24;
    ntp_sec       = ntp_sec_full[5:0];
    ntp_min       = ntp_min_full[5:0];
    ntp_hour_utc  = ntp_hour_full[4:0];
    if (current_utc_offset[4])
      loc_hour = {1'b0, ntp_hour_utc} + {1'b0, current_utc_offset} - 6'h20 + 6'h18;
    else
      loc_hour = {1'b0, ntp_hour_utc} + {1'b0, current_utc_offset};
    if (loc_hour > 6'h17)
      loc_hour = loc_hour - 6'h18;
  end

  // One-second divider; a time load restarts the second so the first tick is a full second later
  always @(posedge ref_clk)
  begin
    if (srst || tick || ld_time || ld_net)
      tick_cnt <= 32'h0;
    else
      tick_cnt <= tick_cnt + 32'h1;
  end

  // Time of day, day count
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      seconds_field     <= 6'h0;
      minutes_field     <= 6'h0;
      hours_field       <= 5'h0;
      elapsed_day_count <= 16'h0;
    end
    else if (ld_time)
    begin
      seconds_field     <= wb_sel_i[0] ? wb_dat_i[`F_SEC_LSB +: 6] : 6'h0;
      minutes_field     <= wb_sel_i[1] ? wb_dat_i[`F_MIN_LSB +: 6] : 6'h0;
      hours_field       <= wb_sel_i[2] ? wb_dat_i[`F_HOUR_LSB +: 5] : 5'h0;
      elapsed_day_count <= 16'h0;
    end
    else if (ld_net)
    begin
      seconds_field     <= ntp_sec;
      minutes_field     <= ntp_min;
      hours_field       <= loc_hour[4:0];
      elapsed_day_count <= 16'h0;
    end
    else if (tick)
    begin
      if (seconds_field == `SEC_MAX)
      begin
        seconds_field <= 6'h0;
        if (minutes_field == `SEC_MAX)
        begin
          minutes_field <= 6'h0;
          if (hours_field == `HOUR_MAX)
          begin
            hours_field       <= 5'h0;
            elapsed_day_count <= elapsed_day_count + 16'h1;
          end
          else
            hours_field <= hours_field + 5'h1;
        end
        else
          minutes_field <= minutes_field + 6'h1;
      end
      else
        seconds_field <= seconds_field + 6'h1;
    end
  end

  // Calendar: no reset term so it survives reset
  always @(posedge ref_clk)
  begin
    if (wb_req && wb_we_i && reg_idx == `A_CAL)
    begin
      weekday_field   <= wb_sel_i[0] ? wb_dat_i[`F_WDAY_LSB +: 3] : 3'h0;
      month_day_field <= wb_sel_i[1] ? wb_dat_i[`F_MDAY_LSB +: 5] : 5'h0;
      month_field     <= wb_sel_i[2] ? wb_dat_i[`F_MON_LSB +: 4] : 4'h0;
      year_field      <= wb_sel_i[3] ? wb_dat_i[`F_YEAR_LSB +: 7] : 7'h0;
    end
    else if (day_wrap && cal_on)
    begin
      weekday_field <= (weekday_field == 3'h7) ? 3'h1 : weekday_field + 3'h1;
      if (month_day_field >= month_len)
      begin
        month_day_field <= 5'h1;
        if (month_field == 4'hC)
        begin
          month_field <= 4'h1;
          year_field  <= (year_field >= `YEAR_MAX) ? 7'h0 : year_field + 7'h1;
        end
        else
          month_field <= month_field + 4'h1;
      end
      else
        month_day_field <= month_day_field + 5'h1;
    end
  end

  // Offset, server value, network load request
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      current_utc_offset     <= 5'h0;
      last_server_time_value <= 32'h0;
      ntp_sod                <= 32'h0;
      ntp_pend               <= 1'b0;
    end
    else
    begin
      ntp_pend <= 1'b0;
      if (wb_req && wb_we_i && reg_idx == `A_OFFSET && wb_sel_i[0])
        current_utc_offset <= wb_dat_i[4:0];
      if (ntp_valid)
      begin
        last_server_time_value <= ntp_seconds;
        ntp_sod                <= ntp_seconds % 86400;
        ntp_pend               <= 1'b1;
      end
    end
  end

  // Register read mux
  always @*
  begin
    rd_data = 32'h0;
    case (reg_idx)
      `A_TIME:   rd_data = {11'h0, hours_field, 2'h0, minutes_field, 2'h0, seconds_field};
      `A_DAYS:   rd_data = {16'h0, elapsed_day_count};
      `A_CAL:    rd_data = {1'b0, year_field, 4'h0, month_field, 3'h0, month_day_field, 5'h0, weekday_field};
      `A_OFFSET: rd_data = {{27{current_utc_offset[4]}}, current_utc_offset};
      `A_SERVER: rd_data = last_server_time_value;
      default:   rd_data = 32'h0;
    endcase
  end

  // Wishbone classic slave, one wait state
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_req)
        wb_dat_o <= rd_data;
    end
  end

endmodule

// >>> verif/time_of_day_calendar_clock_chk.sv
module time_of_day_calendar_clock_chk #(
  parameter TICK_CYCLES = 100000000
)
(
  input wire        ref_clk,
  input wire        srst,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [5:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        ntp_valid,
  input wire [31:0] ntp_seconds
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [31:0] last_ntp;
  wire         rd = wb_ack_o && !wb_we_i;
  wire   [3:0] ix = wb_adr_i[5:2];
  always @(posedge ref_clk)
    last_ntp <= srst ? 32'h0 : (ntp_valid ? ntp_seconds : last_ntp);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_ACK_ONCE: assert property (s_take |=> s_ans) else $error("ack not one pulse");
  AST_NO_SPUR: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  AST_TIME_RANGE: assert property (rd && ix == 4'h0 |-> wb_dat_o[5:0] <= 6'h3B && wb_dat_o[13:8] <= 6'h3B
    && wb_dat_o[20:16] <= 5'h17) else $error("time field out of range");
  AST_CAL_RANGE: assert property (rd && ix == 4'h2 |-> wb_dat_o[2:0] <= 3'h7 && wb_dat_o[12:8] <= 5'h1F
    && wb_dat_o[19:16] <= 4'hC && wb_dat_o[30:24] <= 7'h63) else $error("calendar out of range");
  AST_OFF_RANGE: assert property (rd && ix == 4'h3 |-> $signed(wb_dat_o) >= -12 && $signed(wb_dat_o) <= 12)
    else $error("offset out of range");
  AST_UNMAPPED: assert property (rd && ix > 4'h4 |-> wb_dat_o == 32'h0) else $error("unmapped not zero");
  AST_DAYS_WIDTH: assert property (rd && ix == 4'h1 |-> wb_dat_o[31:16] == 16'h0) else $error("day count wide");
  AST_SERVER: assert property (rd && ix == 4'h4 |-> wb_dat_o == last_ntp) else $error("server copy wrong");
endmodule
bind time_of_day_calendar_clock time_of_day_calendar_clock_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_inst (
  .ref_clk(ref_clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .ntp_valid(ntp_valid), .ntp_seconds(ntp_seconds));

// >>> verif/ntp_source_model.sv
module ntp_source_model (
  input  wire logic        ref_clk,
  input  wire logic        go,
  input  wire logic [31:0] value,
  output logic             ntp_valid,
  output logic [31:0]      ntp_seconds
);
  timeunit 1ns;
  timeprecision 1ns;
  initial ntp_valid = 1'b0;
  initial ntp_seconds = 32'h0;
  // Value is only meaningful with the pulse; it churns otherwise
  always @(posedge ref_clk)
  begin
    ntp_valid <= go;
    ntp_seconds <= go ? value : ~ntp_seconds;
  end
endmodule

// >>> verif/time_of_day_calendar_clock_tb.sv
module time_of_day_calendar_clock_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int T = 50;
  localparam logic [31:0] TM = 32'h001F3F3F;
  localparam logic [31:0] CM = 32'h7F0F1F07;
  logic ref_clk = 0, srst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, go = 0;
  logic [5:0]  wb_adr_i = 6'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, nv = 32'h0, d;
  wire  [31:0] wb_dat_o, ntp_seconds;
  wire         wb_ack_o, ntp_valid;
  int n_fail = 0, comparisons = 0;
  logic [31:0] ci [5] = '{32'h04021C07, 32'h04021D01, 32'h05021C03, 32'h630C1F07, 32'h04041E02};
  logic [31:0] co [5] = '{32'h04021D01, 32'h04030102, 32'h05030104, 32'h00010101, 32'h04050103};
  always #5 ref_clk = ~ref_clk;
  time_of_day_calendar_clock #(.TICK_CYCLES(T)) time_of_day_calendar_clock_inst (
    .ref_clk(ref_clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ntp_valid(ntp_valid), .ntp_seconds(ntp_seconds));
  ntp_source_model ntp_source_model_inst (.ref_clk(ref_clk), .go(go), .value(nv),
    .ntp_valid(ntp_valid), .ntp_seconds(ntp_seconds));
  task automatic xfer(input logic w, input logic [5:0] a, input logic [3:0] s, input logic [31:0] v);
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, s, v};
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    d = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
    comparisons++;
    if ((g & m) !== (e & m))
    begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
    xfer(1'b0, a, 4'hF, 32'h0);
    chk(d, e, m);
  endtask
  // Load 23:59:59 and let the next tick cross midnight
  task automatic eod;
    xfer(1'b1, 6'h00, 4'h7, 32'h00173B3B);
    repeat (T + 4) @(posedge ref_clk);
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    end_sim;
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    rc(6'h00, 32'h0, TM);
    rc(6'h04, 32'h0, '1);
    rc(6'h0C, 32'h0, '1);
    rc(6'h10, 32'h0, '1);
    rc(6'h14, 32'h0, '1);
    rc(6'h3C, 32'h0, '1);
    $display("test reset values done");
    xfer(1'b1, 6'h00, 4'h4, 32'h00053B3B);
    rc(6'h00, 32'h00050000, TM);
    $display("test partial time load done");
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'b1, 6'h08, 4'hF, ci[i]);
      eod;
      rc(6'h08, co[i], CM);
      rc(6'h00, 32'h0, TM);
    end
    $display("test calendar rollover done");
    srst <= 1'b1;
    @(posedge ref_clk);
    srst <= 1'b0;
    rc(6'h08, 32'h04050103, CM);
    xfer(1'b1, 6'h08, 4'hF, 32'h0);
    eod;
    rc(6'h08, 32'h0, CM);
    rc(6'h04, 32'h1, '1);
    xfer(1'b1, 6'h00, 4'h7, 32'h0);
    rc(6'h04, 32'h0, '1);
    $display("test day count done");
    xfer(1'b1, 6'h0C, 4'h1, 32'h1B);
    rc(6'h0C, 32'hFFFFFFFB, '1);
    nv <= 32'h00002332;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rc(6'h10, 32'h00002332, '1);
    rc(6'h00, 32'h00151E0A, TM);
    $display("test network load done");
    end_sim;
  end
endmodule
